/* File: design/tapc_map.svh */
// Constants of the test access port controller
`ifndef TAPC_MAP_SVH
`define TAPC_MAP_SVH
`define TAPC_IR_W         3
`define TAPC_IR_CAPTURE   3'h4
`define TAPC_IR_IDREAD    3'h1
`define TAPC_IR_EXTEST    3'h0
`define TAPC_IR_SAMPLE    3'h2
`define TAPC_IR_BYPASS    3'h7
`define TAPC_BSR_W        8
`define TAPC_ID_W         32
`define TAPC_ID_RESET     32'h1234_5679
`endif

/* File: design/tapc_pkg.sv */
// Types of the test access port controller
package tapc_pkg;
    typedef enum logic [3:0] {
        TAPC_TLR  = 4'h0,
        TAPC_RTI  = 4'h1,
        TAPC_SDR  = 4'h2,
        TAPC_CDR  = 4'h3,
        TAPC_SHDR = 4'h4,
        TAPC_E1DR = 4'h5,
        TAPC_PDR  = 4'h6,
        TAPC_E2DR = 4'h7,
        TAPC_UDR  = 4'h8,
        TAPC_SIR  = 4'h9,
        TAPC_CIR  = 4'ha,
        TAPC_SHIR = 4'hb,
        TAPC_E1IR = 4'hc,
        TAPC_PIR  = 4'hd,
        TAPC_E2IR = 4'he,
        TAPC_UIR  = 4'hf
    } tapc_state_t;
endpackage

/* File: design/tapc_bsr_cell.sv */
// Boundary scan register: shift stages plus latched parallel outputs
`include "tapc_map.svh"
module tapc_bsr_cell
    import tapc_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    input  wire logic                    capture,
    input  wire logic                    shift,
    input  wire logic                    update,
    input  wire logic                    si,
    input  wire logic [`TAPC_BSR_W-1:0]  pin_in,
    output logic      [`TAPC_BSR_W-1:0]  shift_q,
    output logic      [`TAPC_BSR_W-1:0]  par_q
);
    // Shift toward bit 0, which feeds the serial output
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            shift_q <= 8'h00;
        else if (capture)
            shift_q <= pin_in;                          // [RL18]
        else if (shift)
            shift_q <= {si, shift_q[`TAPC_BSR_W-1:1]};
    end

    // Parallel side moves only on the update strobe
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            par_q <= 8'h00;
        else if (update)
            par_q <= shift_q;                           // [RL4] [RL5]
    end
endmodule // tapc_bsr_cell

/* File: design/tapc_ctrl.sv */
// Test access port controller with instruction, id, bypass and boundary paths
`include "tapc_map.svh"
// Summary of operation
// [RL1] Exit1-DR: TMS high Update-DR, low Pause-DR
// [RL2] Pause-DR holds data, waits for TMS high
// [RL3] Exit2-DR: TMS high Update-DR, low Shift-DR
// [RL4] Update-DR latches boundary outputs on TCK fall
// [RL5] Boundary outputs change only in Update-DR
// [RL6] Select-IR: TMS low Capture-IR, high reset
// [RL7] Capture-IR loads pattern 100 into shifter
// [RL8] Capture-IR: TMS high Exit1-IR, low Shift-IR
// [RL9] Shift-IR shifts instruction toward TDO
// [RL10] Exit1-IR: TMS high Update-IR, low Pause-IR
// [RL11] Pause-IR halts, waits for TMS high
// [RL12] Exit2-IR: TMS high Update-IR, low Shift-IR
// [RL13] Update-IR latches instruction on TCK fall
// [RL14] Instruction and data registers hold elsewhere
// [RL15] Sixteen states; five TMS-high edges reset
// [RL16] Reset state loads identification instruction
// [RL17] Idle and Select-DR transitions by TMS
// [RL18] Capture-DR samples pins, Shift-DR shifts data
// [RL19] TDO driven only in shift states
module tapc_ctrl
    import tapc_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    input  wire logic                    tck,
    input  wire logic                    tms,
    input  wire logic                    tdi,
    input  wire logic [`TAPC_BSR_W-1:0]  pin_in,
    output logic                         tdo_o,
    output logic                         tdo_oe,
    output logic [`TAPC_BSR_W-1:0]       bsr_out,
    output logic                         test_mode,
    output logic [`TAPC_IR_W-1:0]        ir_cur,
    output logic [3:0]                   tap_state
);
    // Everything runs on the system clock and the scan clock is only a
    // sampled pin. Limitation: each scan clock phase must last at least
    // two system cycles, or an edge is lost.
    logic [1:0]             tck_s_r;
    logic [1:0]             tms_s_r;
    logic [1:0]             tdi_s_r;
    logic                   tck_d_r;
    logic [`TAPC_BSR_W-1:0] pin_s0_r;
    logic [`TAPC_BSR_W-1:0] pin_s1_r;

    // Scan clock: two stages, plus one more for edge detection
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tck_s_r <= 2'h0;
            tck_d_r <= 1'b0;
        end
        else
        begin
            tck_s_r <= {tck_s_r[0], tck};
            tck_d_r <= tck_s_r[1];
        end
    end

    // Mode and data pins share the scan clock's latency, so they line
    // up with the detected edge that samples them
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tms_s_r <= 2'h0;
            tdi_s_r <= 2'h0;
        end
        else
        begin
            tms_s_r <= {tms_s_r[0], tms};
            tdi_s_r <= {tdi_s_r[0], tdi};
        end
    end

    // Device pin levels for capture; bits may resolve apart, so a
    // capture taken while pins move can mix old and new levels
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s0_r <= 8'h00;
            pin_s1_r <= 8'h00;
        end
        else
        begin
            pin_s0_r <= pin_in;
            pin_s1_r <= pin_s0_r;
        end
    end

    // Edge detection on the synchronised scan clock only; the pin is
    // seen two to three system cycles late, and mode and data with it,
    // so nothing needs a separate alignment stage
    wire tck_rise = tck_s_r[1] & ~tck_d_r;
    wire tck_fall = ~tck_s_r[1] & tck_d_r;
    wire tms_q    = tms_s_r[1];
    wire tdi_q    = tdi_s_r[1];

    tapc_state_t state_r;
    tapc_state_t state_nxt;

    // Next state of the sixteen-state controller; every code is legal,
    // so the case needs no default, and an upset state still walks home
    // to reset within five TMS-high edges
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            // Reset and idle
            TAPC_TLR:  state_nxt = tms_q ? TAPC_TLR  : TAPC_RTI;   // [RL16]
            TAPC_RTI:  state_nxt = tms_q ? TAPC_SDR  : TAPC_RTI;   // [RL17]
            // Data column
            TAPC_SDR:  state_nxt = tms_q ? TAPC_SIR  : TAPC_CDR;   // [RL17]
            TAPC_CDR:  state_nxt = tms_q ? TAPC_E1DR : TAPC_SHDR;  // [RL18]
            TAPC_SHDR: state_nxt = tms_q ? TAPC_E1DR : TAPC_SHDR;  // [RL18]
            TAPC_E1DR: state_nxt = tms_q ? TAPC_UDR  : TAPC_PDR;   // [RL1]
            TAPC_PDR:  state_nxt = tms_q ? TAPC_E2DR : TAPC_PDR;   // [RL2]
            TAPC_E2DR: state_nxt = tms_q ? TAPC_UDR  : TAPC_SHDR;  // [RL3]
            TAPC_UDR:  state_nxt = tms_q ? TAPC_SDR  : TAPC_RTI;
            // Instruction column
            TAPC_SIR:  state_nxt = tms_q ? TAPC_TLR  : TAPC_CIR;   // [RL6]
            TAPC_CIR:  state_nxt = tms_q ? TAPC_E1IR : TAPC_SHIR;  // [RL8]
            TAPC_SHIR: state_nxt = tms_q ? TAPC_E1IR : TAPC_SHIR;  // [RL9]
            TAPC_E1IR: state_nxt = tms_q ? TAPC_UIR  : TAPC_PIR;   // [RL10]
            TAPC_PIR:  state_nxt = tms_q ? TAPC_E2IR : TAPC_PIR;   // [RL11]
            TAPC_E2IR: state_nxt = tms_q ? TAPC_UIR  : TAPC_SHIR;  // [RL12]
            TAPC_UIR:  state_nxt = tms_q ? TAPC_SDR  : TAPC_RTI;
        endcase
    end

    // State moves only on a detected scan clock rise; between rises the
    // controller holds, however long the tester pauses. The graph
    // reaches reset within five TMS-high edges from any state.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            state_r <= TAPC_TLR;                                   // [RL15]
        else if (tck_rise)
            state_r <= state_nxt;                                  // [RL15]
    end

    // Instruction decode, held in the current instruction register;
    // codes without a register of their own fall through to bypass
    logic [`TAPC_IR_W-1:0] ir_shift_r;
    logic [`TAPC_IR_W-1:0] ir_cur_r;
    wire sel_bsr   = (ir_cur_r == `TAPC_IR_EXTEST) | (ir_cur_r == `TAPC_IR_SAMPLE);
    wire sel_id    = (ir_cur_r == `TAPC_IR_IDREAD);
    wire sel_byp   = ~sel_bsr & ~sel_id;
    wire in_tlr    = (state_r == TAPC_TLR);
    wire in_cir    = (state_r == TAPC_CIR);
    wire in_shir   = (state_r == TAPC_SHIR);
    wire in_shdr   = (state_r == TAPC_SHDR);
    wire in_uir    = (state_r == TAPC_UIR);
    wire dr_cap    = tck_rise & (state_r == TAPC_CDR);
    wire dr_shift  = tck_rise & in_shdr;
    wire dr_update = tck_fall & (state_r == TAPC_UDR);

    // Instruction shifter: capture pattern, then shift toward TDO; the
    // fixed low bits show a tester that the serial path is intact
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ir_shift_r <= `TAPC_IR_CAPTURE;
        else if (tck_rise && in_cir)
            ir_shift_r <= `TAPC_IR_CAPTURE;                        // [RL7]
        else if (tck_rise && in_shir)
            ir_shift_r <= {tdi_q, ir_shift_r[`TAPC_IR_W-1:1]};     // [RL9]
    end

    // Current instruction changes only in reset and on the falling edge in Update-IR;
    // waiting for the fall keeps a new code from meeting a rising-edge
    // capture or shift of the same scan cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ir_cur_r <= `TAPC_IR_IDREAD;
        else if (in_tlr)
            ir_cur_r <= `TAPC_IR_IDREAD;                           // [RL16]
        else if (tck_fall && in_uir)
            ir_cur_r <= ir_shift_r;                                // [RL13] [RL14]
    end

    // Identification and bypass data registers
    logic [`TAPC_ID_W-1:0] id_r;
    logic                  byp_r;

    // Identification word reloads on capture and shifts only while
    // selected, so pause and exit states leave it untouched
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            id_r <= `TAPC_ID_RESET;
        else if (dr_cap)
            id_r <= `TAPC_ID_RESET;
        else if (dr_shift && sel_id)                               // [RL2] [RL14]
            id_r <= {tdi_q, id_r[`TAPC_ID_W-1:1]};                 // [RL18]
    end

    // Bypass stage: one bit of delay, cleared on capture so a tester
    // can count the devices on a chain by the leading zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            byp_r <= 1'b0;
        else if (dr_cap)
            byp_r <= 1'b0;
        else if (dr_shift && sel_byp)
            byp_r <= tdi_q;
    end

    // Boundary register with its latched parallel side; captures see
    // the synchronised pins, two system cycles behind the real levels
    logic [`TAPC_BSR_W-1:0] bsr_shift;
    logic [`TAPC_BSR_W-1:0] bsr_par;

    tapc_bsr_cell u_bsr (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .capture (dr_cap & sel_bsr),
        .shift   (dr_shift & sel_bsr),
        .update  (dr_update & sel_bsr),
        .si      (tdi_q),
        .pin_in  (pin_s1_r),
        .shift_q (bsr_shift),
        .par_q   (bsr_par)
    );

    // Serial output source for the state being shifted
    wire dr_bit  = sel_bsr ? bsr_shift[0] : (sel_id ? id_r[0] : byp_r);
    wire tdo_nxt = in_shir ? ir_shift_r[0] : dr_bit;

    // Serial data, retimed so the pin never shows a decode glitch;
    // it changes three to four system cycles after each scan clock rise
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tdo_o <= 1'b0;
        else
            tdo_o <= tdo_nxt;
    end

    // Driver enable: the pin floats outside the two shift states, so
    // several devices may share one serial return line
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tdo_oe <= 1'b0;
        else
            tdo_oe <= in_shir | in_shdr;                           // [RL19]
    end

    // Boundary parallel outputs, one system cycle behind the latch;
    // shifting never reaches them, only the update strobe does
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            bsr_out <= 8'h00;
        else
            bsr_out <= bsr_par;                                    // [RL5]
    end

    // External test takes the pins only outside reset, so a stuck
    // tester holding TMS high always hands them back
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            test_mode <= 1'b0;
        else
            test_mode <= ~in_tlr & (ir_cur_r == `TAPC_IR_EXTEST);  // [RL16]
    end

    // Current instruction as seen outside, registered like the state code
    // below so both lag their sources by one system cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ir_cur <= `TAPC_IR_IDREAD;
        else
            ir_cur <= ir_cur_r;
    end

    // Controller state code for observation
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tap_state <= 4'h0;
        else
            tap_state <= state_r;
    end
endmodule // tapc_ctrl

/* File: dv/tapc_ctrl_sva.sv */
// Port assertions of the test access port controller
`include "tapc_map.svh"
module tapc_ctrl_sva
    import tapc_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   rstn,
    input wire logic                   tck,
    input wire logic                   tdo_o,
    input wire logic                   tdo_oe,
    input wire logic [`TAPC_BSR_W-1:0] bsr_out,
    input wire logic                   test_mode,
    input wire logic [`TAPC_IR_W-1:0]  ir_cur,
    input wire logic [3:0]             tap_state
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] NX0 = 64'h1bdd_bba1_4664_4311;
    localparam logic [63:0] NX1 = 64'h2fef_cc02_8785_5920;
    logic [3:0] st_r;
    logic       tck_r;
    logic [3:0] age_r;
    wire  logic [3:0] age_nxt = (tck && !tck_r) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Previous state, and cycles since the scan clock pin last rose
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r  <= 4'h0;
            tck_r <= 1'h0;
            age_r <= 4'hf;
        end
        else
        begin
            st_r  <= tap_state;
            tck_r <= tck;
            age_r <= age_nxt;
        end
    end
    step_legal_a: assert property (tap_state != st_r |-> tap_state == NX0[{st_r, 2'h0} +: 4]
        || tap_state == NX1[{st_r, 2'h0} +: 4]) else $error("illegal state step");
    step_time_a: assert property ($changed(tap_state) |-> age_r inside {[1:7]})
        else $error("state moved without scan clock rise");
    oe_shift_a: assert property (tdo_oe == (tap_state == TAPC_SHDR || tap_state == TAPC_SHIR))
        else $error("serial out enable outside shift");
    bsr_hold_a: assert property ($changed(bsr_out) |-> tap_state == TAPC_UDR)
        else $error("boundary outputs moved outside update");
    ir_hold_a: assert property ($changed(ir_cur) |-> tap_state inside {TAPC_UIR, TAPC_TLR})
        else $error("instruction moved outside update");
    reset_ir_a: assert property ((tap_state == TAPC_TLR) [*3] |-> ir_cur == `TAPC_IR_IDREAD
        && !test_mode) else $error("reset state lost identification");
    mode_src_a: assert property ($rose(test_mode) |-> ir_cur == `TAPC_IR_EXTEST)
        else $error("test mode without external test");
    cap_first_a: assert property (tap_state == TAPC_SHIR && st_r == TAPC_CIR |-> ##1
        !tdo_o && tdo_oe) else $error("capture pattern first bit wrong");
endmodule // tapc_ctrl_sva
bind tapc_ctrl tapc_ctrl_sva i_tapc_ctrl_sva (.sys_clk, .rstn, .tck, .tdo_o, .tdo_oe,
    .bsr_out, .test_mode, .ir_cur, .tap_state);

/* File: dv/tapc_tester.sv */
// Boundary-scan tester model making scan clock, mode and data
module tapc_tester
(
    input  wire logic sys_clk,
    input  wire logic tdo_o,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    event done;
    // Scan clock idles low between frames
    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end
    // One scan clock of 20 cycles; mode held well past the synchroniser
    task automatic pulse(input logic m, input logic d, output logic q);
        @(negedge sys_clk);
        tms = m;
        tdi = d;
        repeat (3) @(negedge sys_clk);
        q   = tdo_o;
        tck = 1'h1;
        repeat (10) @(negedge sys_clk);
        tck = 1'h0;
        repeat (6) @(negedge sys_clk);
        tdi = ~d; // Hold ran out: show a changed level
        -> done;
    endtask
endmodule // tapc_tester

/* File: dv/test_tapc_ctrl.sv */
// Self-checking bench for the test access port controller
`include "tapc_map.svh"
module test_tapc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import tapc_pkg::*;
    localparam logic [63:0] NX0 = 64'h1bdd_bba1_4664_4311;
    localparam logic [63:0] NX1 = 64'h2fef_cc02_8785_5920;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic tck, tms, tdi, tdo_o, tdo_oe, test_mode;
    logic [`TAPC_BSR_W-1:0] pin_in = 8'h00, bsr_out, sh, pv, dv;
    logic [`TAPC_IR_W-1:0] ir_cur;
    logic [3:0] tap_state, st = 4'h0, e;
    logic [31:0] seed = 32'h0000_0022;
    logic [3:0] exp_q[$];
    int n_fail = 0;
    int n_checks = 0;
    tapc_ctrl i_tapc_ctrl (.sys_clk, .rstn, .tck, .tms, .tdi, .pin_in, .tdo_o, .tdo_oe,
        .bsr_out, .test_mode, .ir_cur, .tap_state);
    tapc_tester i_tapc_tester (.sys_clk, .tdo_o, .tck, .tms, .tdi);
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: saw %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Note next state from the graph, clock it, collect shifted-out bits
    task automatic run(input int n, input logic [15:0] m, input logic [15:0] d);
        logic       q;
        logic [3:0] prv;
        for (int i = 0; i < n; i++)
        begin
            prv = st;
            st = m[i] ? NX1[{st, 2'h0} +: 4] : NX0[{st, 2'h0} +: 4];
            exp_q.push_back(st);
            i_tapc_tester.pulse(m[i], d[i], q);
            if (prv == TAPC_SHDR || prv == TAPC_SHIR)
                sh = {q, sh[7:1]};
        end
    endtask
    // Monitor: each settled step against the oldest noted state
    initial
    begin
        forever
        begin
            @(i_tapc_tester.done);
            e = exp_q.pop_front();
            chk(tap_state, e);
            chk(tdo_oe, e == TAPC_SHDR || e == TAPC_SHIR);
        end
    end
    // Watchdog: the tests need about 7 us
    initial
    begin
        #50us;
        n_fail++;
        finish_test;
    end
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rstn = 1'h1;
        repeat (3) @(negedge sys_clk);
        chk(ir_cur, `TAPC_IR_IDREAD);
        run(12, 16'h0d46, 16'h0000);
        chk(sh[7:5], `TAPC_IR_CAPTURE);
        chk(ir_cur, `TAPC_IR_EXTEST);
        chk(test_mode, 1'h1);
        $display("instruction scan test done");
        seed = xs(seed);
        pin_in = seed[7:0];
        pv = seed[7:0];
        dv = seed[15:8];
        run(15, 16'h4802, {4'h0, dv, 4'h0});
        chk(bsr_out, 8'h00);
        chk(sh, pv);
        run(1, 16'h0001, 16'h0000);
        chk(bsr_out, dv);
        seed = xs(seed);
        pin_in = seed[7:0];
        run(4, 16'h000d, 16'h0000);
        chk(bsr_out, pin_in);
        $display("data scan test done");
        run(3, 16'h0007, 16'h0000);
        chk(ir_cur, `TAPC_IR_IDREAD);
        run(9, 16'h01f2, 16'h0000); // Five TMS-high edges out of Shift-DR
        chk(test_mode, 1'h0);
        $display("reset path test done");
        finish_test;
    end
endmodule // test_tapc_ctrl
